// [verilog/mdsfc_pkg.sv]
// Shared constants of the motor driver mode, fault and serial control block.
// Assumes a single 25 MHz reference clock; all times below are turned into cycles here.
package mdsfc_pkg;

    // Reference clock
    localparam real CLK_PERIOD_NS = 40.0;

    // Power-up status pulse, least time, rounded up
    localparam real PO_MIN_US     = 1.0;
    localparam int  PO_MIN_CYC    = int'($ceil(PO_MIN_US * 1000.0 / CLK_PERIOD_NS));
    // Enable high to status released, longest time, rounded down
    localparam real TURN_ON_MS    = 1.0;
    localparam int  TURN_ON_CYC   = int'($floor(TURN_ON_MS * 1.0e6 / CLK_PERIOD_NS));
    // Enable low to power-down start, least of the window, rounded up
    localparam real PD_DLY_US     = 8.0;
    localparam int  PD_DLY_CYC    = int'($ceil(PD_DLY_US * 1000.0 / CLK_PERIOD_NS));
    // Preceding pulse that guarantees a pin clear event
    localparam real CLR_PULSE_US  = 1.0;
    localparam int  CLR_PULSE_CYC = int'($ceil(CLR_PULSE_US * 1000.0 / CLK_PERIOD_NS));

    // Serial word
    localparam int  WORD_BITS     = 16;
    localparam int  BIT_RW        = 15;
    localparam int  SEL_HI        = 14;
    localparam int  SEL_LO        = 13;
    localparam int  PAYLOAD_BITS  = 13;

    // Register select codes
    localparam logic [1:0] SEL_ID     = 2'h0;
    localparam logic [1:0] SEL_STATUS = 2'h1;
    localparam logic [1:0] SEL_MASK   = 2'h2;
    localparam logic [1:0] SEL_CONFIG = 2'h3;

    // Status layout: framing flag above eleven fault bits
    localparam int  FAULT_BITS    = 11;
    localparam int  FRM_BIT       = 11;
    localparam int  CPUV_BIT      = 10;

    // Reset values of the writable payloads
    localparam logic [12:0] MASK_RST   = 13'h06f1;
    localparam logic [12:0] CONFIG_RST = 13'h0d98;
    // Output enable bit of the configuration payload
    localparam int  CFG_EN_BIT    = 4;

    // Identification payload; bit 4 fixed, low nibble arbitrary neutral value
    localparam logic [12:0] ID_PAYLOAD = 13'h0010;
    localparam logic [3:0]  ID_REV     = 4'h0;

    // Mode machine, one-hot
    typedef enum logic [5:0] {
        ST_SLEEP     = 6'h01,
        ST_POWERUP   = 6'h02,
        ST_STANDBY   = 6'h04,
        ST_NORMAL    = 6'h08,
        ST_FAULT     = 6'h10,
        ST_POWERDOWN = 6'h20
    } mdsfc_state_t;

endpackage

// [verilog/mdsfc_sync.sv]
// Two-stage synchroniser for pins that arrive from outside the reference clock domain.
// Assumes the caller reads only the second stage.
`timescale 1ns/1ns
`default_nettype none
module mdsfc_sync #(
    parameter int WIDTH = 1
) (
    // Clock, reset, enable
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             clk_en,
    // Asynchronous inputs
    input  wire logic [WIDTH-1:0] async_in,
    // Synchronised outputs
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;   // First stage, read only by the second
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;   // Second stage
    logic [WIDTH-1:0] sync_nxt;

    // Next values of both stages
    always_comb
    begin
        meta_nxt = meta_r;
        sync_nxt = sync_r;
        if (clk_en)
        begin
            meta_nxt = async_in;
            sync_nxt = meta_r;
        end
    end

    // Stage registers
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule
`default_nettype wire

// [verilog/mdsfc_top.sv]
// Mode machine, fault latching and 16-bit serial slave of a motor driver.
// Assumes all pins are asynchronous to ref_clk and are oversampled by it.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R01: Sleep disables all activity and drive.
// R02: Standby runs logic and serial port; bridge off.
// R03: Normal runs everything; faults enter fault mode.
// R04: Fault mode forces bridge off, status low.
// R05: Enable high with supply good starts power-up.
// R06: Status low at least pulse, then released.
// R07: Status released within turn-on time.
// R08: Enable low: bridge off, status low at once.
// R09: Power-down starts after delay; then status released.
// R10: Release only with disable low; low through power-down.
// R11: Sixteen-bit words, MSB first, slave only.
// R12: Sample on falling, change on rising clock.
// R13: Master keeps serial clock at most 10 MHz.
// R14: Bits beyond sixteen pass down daisy chain.
// R15: Bad clock count: ignore, set framing flag.
// R16: Chip select fall loads previously selected register.
// R17: First transfer after enable returns status.
// R18: Read commands ignore payload bits.
// R19: Master verifies writes and detects malfunctions.
// R20: Faults latch when detected, held until cleared.
// R21: Clear needs fault gone plus clear event.
// R22: Status register write is a clear event.
// R23: Disable falling edge after long pulse clears.
// R24: Enable rising edge after long pulse clears.
// R25: Bit fifteen one writes, zero reads.
// R26: Write to select zero is framing error.
// R27: Command acted on at chip select rise.
module mdsfc_top #(
    parameter int TURN_ON_CYC = mdsfc_pkg::TURN_ON_CYC  // Power-up timeout
) (
    // Clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    // Control pins
    input  wire logic        driver_enable_pin,
    input  wire logic        disable_pin,
    // Analog monitors
    input  wire logic        supply_ok,
    input  wire logic        supplies_ready,
    input  wire logic [10:0] fault_in,
    // Serial link
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    // Status and bridge control
    output logic             fault_status_n,
    output logic             bridge_hiz,
    output logic             supplies_on,
    output logic [5:0]       mode_state,
    // Register contents
    output logic [11:0]      status_flags,
    output logic [12:0]      mask_reg,
    output logic [12:0]      config_reg
);

    // Timer width covers both the turn-on limit and the power-down delay
    localparam int TW = $clog2(((TURN_ON_CYC > mdsfc_pkg::PD_DLY_CYC) ? TURN_ON_CYC
                                : mdsfc_pkg::PD_DLY_CYC) + 1);
    localparam int PW = $clog2(mdsfc_pkg::CLR_PULSE_CYC + 1);

    // Synchronised pins
    logic [17:0] pins_s;
    logic        cs_s, sclk_s, mosi_s, en_s, dis_s, sok_s, rdy_s;
    logic [10:0] flt_s;

    mdsfc_sync #(
        .WIDTH (18)
    ) u_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .async_in ({fault_in, supplies_ready, supply_ok, disable_pin,
                    driver_enable_pin, mosi, sclk, cs_n}),
        .sync_out (pins_s)
    );

    assign {flt_s, rdy_s, sok_s, dis_s, en_s, mosi_s, sclk_s, cs_s} = pins_s;

    // Edge history and pulse-width counters
    logic          cs_q_r, sclk_q_r, en_q_r, dis_q_r;
    logic          cs_q_nxt, sclk_q_nxt, en_q_nxt, dis_q_nxt;
    logic [PW-1:0] en_lo_r, dis_hi_r, en_lo_nxt, dis_hi_nxt;
    logic          cs_fall, cs_rise, sclk_fall, sclk_rise;
    logic          en_rise, en_fall, dis_fall;
    logic          clr_pin;     // Qualified pin clear event

    assign cs_fall   = cs_q_r & ~cs_s;
    assign cs_rise   = ~cs_q_r & cs_s;
    assign sclk_fall = sclk_q_r & ~sclk_s;
    assign sclk_rise = ~sclk_q_r & sclk_s;
    assign en_rise   = ~en_q_r & en_s;
    assign en_fall   = en_q_r & ~en_s;
    assign dis_fall  = dis_q_r & ~dis_s;
    assign clr_pin   = (dis_fall & (dis_hi_r == PW'(mdsfc_pkg::CLR_PULSE_CYC)))  // R23
                     | (en_rise & (en_lo_r == PW'(mdsfc_pkg::CLR_PULSE_CYC)));   // R24

    // Edge history and saturating pulse counters
    always_comb
    begin
        cs_q_nxt   = cs_s;
        sclk_q_nxt = sclk_s;
        en_q_nxt   = en_s;
        dis_q_nxt  = dis_s;
        en_lo_nxt  = en_lo_r;
        dis_hi_nxt = dis_hi_r;
        if (en_s)
            en_lo_nxt = '0;
        else if (en_lo_r != PW'(mdsfc_pkg::CLR_PULSE_CYC))
            en_lo_nxt = en_lo_r + PW'(1);
        if (!dis_s)
            dis_hi_nxt = '0;
        else if (dis_hi_r != PW'(mdsfc_pkg::CLR_PULSE_CYC))
            dis_hi_nxt = dis_hi_r + PW'(1);
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cs_q_r   <= 1'b1;
            sclk_q_r <= 1'b0;
            en_q_r   <= 1'b0;
            dis_q_r  <= 1'b0;
            en_lo_r  <= '0;
            dis_hi_r <= '0;
        end
        else if (clk_en)
        begin
            cs_q_r   <= cs_q_nxt;
            sclk_q_r <= sclk_q_nxt;
            en_q_r   <= en_q_nxt;
            dis_q_r  <= dis_q_nxt;
            en_lo_r  <= en_lo_nxt;
            dis_hi_r <= dis_hi_nxt;
        end
    end

    // Mode state and timers
    mdsfc_pkg::mdsfc_state_t state_r, state_nxt;
    logic [TW-1:0] tmr_r, tmr_nxt;    // Time in power-up or power-down
    logic [PW-1:0] po_r, po_nxt;      // Status pulse length since supplies ready
    logic [10:0]   lat_r, lat_nxt;    // Latched faults
    logic          frm_r, frm_nxt;    // Framing error flag
    logic          masked_flt;
    logic          sleeping;

    assign sleeping   = (state_r == mdsfc_pkg::ST_SLEEP);
    assign masked_flt = |(lat_r & mask_reg[10:0]);

    // Next mode
    always_comb
    begin
        state_nxt = state_r;
        tmr_nxt   = tmr_r;
        po_nxt    = po_r;
        unique case (state_r)
            mdsfc_pkg::ST_SLEEP:
            begin
                // Only a wake-up with a good supply leaves sleep
                tmr_nxt = '0;
                po_nxt  = '0;
                if (en_s && sok_s)
                    state_nxt = mdsfc_pkg::ST_POWERUP; // R05
            end
            mdsfc_pkg::ST_POWERUP:
            begin
                if (tmr_r != TW'(TURN_ON_CYC))
                    tmr_nxt = tmr_r + TW'(1);
                if ((rdy_s || po_r != '0) && po_r != PW'(mdsfc_pkg::PO_MIN_CYC))
                    po_nxt = po_r + PW'(1);
                if (!en_s)
                begin
                    state_nxt = mdsfc_pkg::ST_POWERDOWN;
                    tmr_nxt   = '0;
                end
                else if (po_r == PW'(mdsfc_pkg::PO_MIN_CYC) && !flt_s[mdsfc_pkg::CPUV_BIT]
                         && lat_r == '0)
                    state_nxt = mdsfc_pkg::ST_STANDBY; // R06
                else if (tmr_r == TW'(TURN_ON_CYC))
                    state_nxt = mdsfc_pkg::ST_FAULT; // R07
            end
            mdsfc_pkg::ST_STANDBY, mdsfc_pkg::ST_NORMAL:
            begin
                // Normal needs the output enable bit and disable low
                if (!en_s)
                begin
                    state_nxt = mdsfc_pkg::ST_POWERDOWN;
                    tmr_nxt   = '0;
                end
                else if (state_r == mdsfc_pkg::ST_NORMAL && masked_flt)
                    state_nxt = mdsfc_pkg::ST_FAULT; // R03
                else if (config_reg[mdsfc_pkg::CFG_EN_BIT] && !dis_s)
                    state_nxt = mdsfc_pkg::ST_NORMAL;
                else
                    state_nxt = mdsfc_pkg::ST_STANDBY; // R02
            end
            mdsfc_pkg::ST_FAULT:
            begin
                // Held until all latched faults are cleared, masked or not
                if (!en_s)
                begin
                    state_nxt = mdsfc_pkg::ST_POWERDOWN;
                    tmr_nxt   = '0;
                end
                else if (!masked_flt && lat_r == '0)
                    state_nxt = mdsfc_pkg::ST_STANDBY; // R04
            end
            mdsfc_pkg::ST_POWERDOWN:
            begin
                // Supplies stay on for the delay, then switch off
                tmr_nxt = tmr_r + TW'(1);
                if (tmr_r == TW'(mdsfc_pkg::PD_DLY_CYC - 1))
                    state_nxt = mdsfc_pkg::ST_SLEEP; // R09
            end
            default:
                state_nxt = mdsfc_pkg::ST_SLEEP;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_r <= mdsfc_pkg::ST_SLEEP;
            tmr_r   <= '0;
            po_r    <= '0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            tmr_r   <= tmr_nxt;
            po_r    <= po_nxt;
        end
    end

    // Serial shifter state
    logic [15:0] sh_r, sh_nxt;      // Shift register, also the daisy-chain path
    logic [3:0]  bits_r, bits_nxt;  // Clock count modulo sixteen
    logic        any_r, any_nxt;    // At least one clock seen
    logic        miso_r, miso_nxt;
    logic [1:0]  sel_r, sel_nxt;    // Register selected by the previous transfer
    logic [12:0] mask_nxt, cfg_nxt;
    logic [15:0] rd_word;
    logic        frame_ok, wr, stat_wr;
    logic [15:0] cmd;

    assign cmd      = sh_r;
    assign frame_ok = any_r && bits_r == 4'h0; // R15
    assign wr       = cmd[mdsfc_pkg::BIT_RW]; // R25
    assign stat_wr  = cs_rise && frame_ok && wr
                    && cmd[mdsfc_pkg::SEL_HI:mdsfc_pkg::SEL_LO] == mdsfc_pkg::SEL_STATUS;

    // Word of the selected register
    always_comb
    begin
        unique case (sel_r)
            mdsfc_pkg::SEL_ID:     rd_word = {1'b0, sel_r,
                                              mdsfc_pkg::ID_PAYLOAD | {9'h000, mdsfc_pkg::ID_REV}};
            mdsfc_pkg::SEL_STATUS: rd_word = {1'b0, sel_r, 1'b0, frm_r, lat_r};
            mdsfc_pkg::SEL_MASK:   rd_word = {1'b0, sel_r, mask_reg};
            mdsfc_pkg::SEL_CONFIG: rd_word = {1'b0, sel_r, config_reg};
        endcase
    end

    // Serial shifting and command decode
    always_comb
    begin
        sh_nxt   = sh_r;
        bits_nxt = bits_r;
        any_nxt  = any_r;
        miso_nxt = miso_r;
        sel_nxt  = sel_r;
        mask_nxt = mask_reg;
        cfg_nxt  = config_reg;
        if (sleeping)
        begin
            // Port dead in sleep; wake selects status
            sel_nxt  = mdsfc_pkg::SEL_STATUS; // R01 R17
            mask_nxt = mdsfc_pkg::MASK_RST;
            cfg_nxt  = mdsfc_pkg::CONFIG_RST;
        end
        else if (cs_fall)
        begin
            sh_nxt   = rd_word; // R16
            miso_nxt = rd_word[15];
            bits_nxt = '0;
            any_nxt  = 1'b0;
        end
        else if (!cs_s && sclk_rise)
            miso_nxt = sh_r[15]; // R12
        else if (!cs_s && sclk_fall)
        begin
            // Oldest bit exits toward the next device
            sh_nxt   = {sh_r[14:0], mosi_s}; // R11 R12 R14
            bits_nxt = bits_r + 4'h1;
            any_nxt  = 1'b1;
        end
        else if (cs_rise && frame_ok)
        begin
            // Last sixteen bits are the command
            sel_nxt = cmd[mdsfc_pkg::SEL_HI:mdsfc_pkg::SEL_LO]; // R27
            if (wr && sel_nxt == mdsfc_pkg::SEL_MASK)
                mask_nxt = cmd[12:0];
            else if (wr && sel_nxt == mdsfc_pkg::SEL_CONFIG)
                cfg_nxt = cmd[12:0]; // R18
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sh_r       <= '0;
            bits_r     <= '0;
            any_r      <= 1'b0;
            miso_r     <= 1'b0;
            sel_r      <= mdsfc_pkg::SEL_STATUS;
            mask_reg   <= mdsfc_pkg::MASK_RST;
            config_reg <= mdsfc_pkg::CONFIG_RST;
        end
        else if (clk_en)
        begin
            sh_r       <= sh_nxt;
            bits_r     <= bits_nxt;
            any_r      <= any_nxt;
            miso_r     <= miso_nxt;
            sel_r      <= sel_nxt;
            mask_reg   <= mask_nxt;
            config_reg <= cfg_nxt;
        end
    end

    // Fault latching; a set beats a clear
    logic [10:0] clr_mask;
    logic        frm_set;

    assign frm_set = cs_rise && !sleeping
                   && (!frame_ok // R15
                       || (wr && cmd[mdsfc_pkg::SEL_HI:mdsfc_pkg::SEL_LO] == mdsfc_pkg::SEL_ID)); // R26

    always_comb
    begin
        clr_mask = '0;
        if (clr_pin)
            clr_mask = '1;
        if (stat_wr)
            clr_mask = clr_mask | cmd[10:0]; // R22
        lat_nxt = lat_r & ~(clr_mask & ~flt_s); // R21
        frm_nxt = frm_r & ~(clr_pin | (stat_wr & cmd[mdsfc_pkg::FRM_BIT]));
        if (!sleeping)
        begin
            lat_nxt = lat_nxt | flt_s; // R20
            frm_nxt = frm_nxt | frm_set;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            lat_r <= '0;
            frm_r <= 1'b0;
        end
        else if (clk_en)
        begin
            lat_r <= lat_nxt;
            frm_r <= frm_nxt;
        end
    end

    // Pin outputs
    logic fs_low;

    always_comb
    begin
        fs_low = dis_s; // R10
        unique case (state_r)
            mdsfc_pkg::ST_SLEEP:     fs_low = 1'b0; // R01
            mdsfc_pkg::ST_POWERUP:   fs_low = fs_low | rdy_s | (po_r != '0); // R06
            mdsfc_pkg::ST_FAULT:     fs_low = 1'b1; // R04
            mdsfc_pkg::ST_POWERDOWN: fs_low = 1'b1; // R09 R10
            default:                 fs_low = fs_low | ~en_s; // R08
        endcase
    end

    assign fault_status_n = ~fs_low;
    assign bridge_hiz     = ~(state_r == mdsfc_pkg::ST_NORMAL) | ~en_s; // R02 R08
    assign supplies_on    = ~sleeping;
    assign mode_state     = state_r;
    assign status_flags   = {frm_r, lat_r};
    assign miso           = miso_r;
    assign miso_oe        = ~cs_s & ~sleeping; // R01

endmodule
`default_nettype wire

// [bench/mdsfc_monitor.sv]
// Checker of mode sequencing, status pin and serial framing of mdsfc_top.
// Assumes it is bound to mdsfc_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module mdsfc_monitor #(
    parameter int TURN_ON_CYC = 100  // Turn-on limit handed on by the bind
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // Serial select and output enable
    input wire logic        cs_n,
    input wire logic        miso_oe,
    // Status, bridge and mode
    input wire logic        fault_status_n,
    input wire logic        bridge_hiz,
    input wire logic        supplies_on,
    input wire logic [5:0]  mode_state,
    // Register contents
    input wire logic [11:0] status_flags,
    input wire logic [12:0] mask_reg
);
    logic [9:0]  pd_cnt_r;    // Cycles spent in power-down
    logic [9:0]  pd_cnt_nxt;
    logic [15:0] lo_cnt_r;    // Cycles the status pin has been low
    logic [15:0] lo_cnt_nxt;
    logic [15:0] pu_cnt_r;    // Cycles spent in power-up
    logic [15:0] pu_cnt_nxt;

    // Next values of the helper counters
    always_comb
    begin
        pd_cnt_nxt = (mode_state == mdsfc_pkg::ST_POWERDOWN) ? pd_cnt_r + 10'h001 : 10'h000;
        lo_cnt_nxt = fault_status_n ? 16'h0000 : lo_cnt_r + 16'h0001;
        pu_cnt_nxt = (mode_state == mdsfc_pkg::ST_POWERUP) ? pu_cnt_r + 16'h0001 : 16'h0000;
    end

    // Helper counter registers
    always_ff @(posedge ref_clk)
    begin
        pd_cnt_r <= srst ? 10'h000 : pd_cnt_nxt;
        lo_cnt_r <= srst ? 16'h0000 : lo_cnt_nxt;
        pu_cnt_r <= srst ? 16'h0000 : pu_cnt_nxt;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sleep_quiet_a: assert property (mode_state == mdsfc_pkg::ST_SLEEP |->
        !miso_oe && !supplies_on && bridge_hiz && fault_status_n) else $error("sleep active");
    standby_hiz_a: assert property (mode_state == mdsfc_pkg::ST_STANDBY |-> bridge_hiz)
        else $error("standby drives bridge");
    normal_fault_a: assert property (mode_state == mdsfc_pkg::ST_NORMAL
        && |(status_flags[10:0] & mask_reg[10:0]) |-> ##[1:3] mode_state == mdsfc_pkg::ST_FAULT)
        else $error("fault mode not entered");
    fault_pin_a: assert property (mode_state == mdsfc_pkg::ST_FAULT |->
        !fault_status_n && bridge_hiz) else $error("fault mode pin high");
    pd_hold_a: assert property (mode_state == mdsfc_pkg::ST_POWERDOWN |->
        !fault_status_n && bridge_hiz) else $error("power-down pin high");
    pd_delay_a: assert property (mode_state != mdsfc_pkg::ST_POWERDOWN &&
        $past(mode_state) == mdsfc_pkg::ST_POWERDOWN |-> pd_cnt_r >= 10'd195 &&
        pd_cnt_r <= 10'd275) else $error("power-down delay wrong");
    po_pulse_a: assert property ($rose(fault_status_n) &&
        $past(mode_state) == mdsfc_pkg::ST_POWERUP |-> lo_cnt_r >= mdsfc_pkg::PO_MIN_CYC)
        else $error("power-up pulse short");
    turn_on_a: assert property (mode_state == mdsfc_pkg::ST_POWERUP |->
        pu_cnt_r < TURN_ON_CYC + 4) else $error("turn-on too long");
    oe_idle_a: assert property (cs_n [*6] |-> !miso_oe)
        else $error("miso driven while deselected");
    frm_at_end_a: assert property ($rose(status_flags[mdsfc_pkg::FRM_BIT]) |-> $past(cs_n))
        else $error("framing flag inside frame");
    mask_at_end_a: assert property (!$stable(mask_reg) &&
        mode_state != mdsfc_pkg::ST_SLEEP |-> $past(cs_n)) else $error("mask changed in frame");
endmodule

bind mdsfc_top mdsfc_monitor #(.TURN_ON_CYC(TURN_ON_CYC)) mon_u (.ref_clk(ref_clk),
    .srst(srst), .cs_n(cs_n), .miso_oe(miso_oe), .fault_status_n(fault_status_n),
    .bridge_hiz(bridge_hiz), .supplies_on(supplies_on), .mode_state(mode_state),
    .status_flags(status_flags), .mask_reg(mask_reg));
`default_nettype wire

// [bench/mdsfc_host_model.sv]
// Host serial master model for the motor driver block.
// Assumes a 320 ns link clock, idle low, with pulled lines at their rest level.
`timescale 1ns/1ns
`default_nettype none
module mdsfc_host_model (
    // Link toward the device
    output logic      cs_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    localparam int HALF_NS = 160;  // Half period, well under the top rate

    // Rest levels: select pulled up, clock and data pulled down
    initial
        {cs_n, sclk, mosi} = 3'b100;

    // One frame of nbits, MSB first; rx taken at each falling edge
    task automatic xfer(input int nbits, input logic [31:0] tx, output logic [31:0] rx);
        int i;
        rx = 32'h0000_0000;
        #13;
        cs_n = 1'b0;
        #(2 * HALF_NS);
        for (i = nbits - 1; i >= 0; i--)
        begin
            sclk = 1'b1;
            mosi = tx[i];   // Data changes on the rise, highest first
            #HALF_NS;
            rx = {rx[30:0], miso_oe ? miso : 1'bx};  // Valid at the fall
            sclk = 1'b0;    // Device samples here
            #HALF_NS;
        end
        #(2 * HALF_NS);
        cs_n = 1'b1;
        mosi = 1'b0;        // Back to pull-down level
        #(2 * HALF_NS);     // Gap between frames
    endtask
endmodule
`default_nettype wire

// [bench/tb_motor_driver_spi_mode_fault_ctrl.sv]
// Self-checking bench of the motor driver mode, fault and serial block.
// Assumes the host model drives the link; pins and monitors are driven here.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_motor_driver_spi_mode_fault_ctrl;
    typedef struct packed {logic [15:0] tx; logic [12:0] exp;} mdsfc_row_t;
    localparam int TON = 100;  // Shortened turn-on limit
    // Clock, reset and pins
    logic        ref_clk = 1'b0;
    logic        srst    = 1'b1;
    logic        en_pin  = 1'b0;
    logic        dis_pin = 1'b0;
    logic        sup_ok  = 1'b1;
    logic        sup_rdy = 1'b1;
    logic [10:0] flt     = 11'h000;
    // Link and outputs
    logic        cs_n, sclk, mosi, miso, miso_oe, fs_n, hiz, sup_on;
    logic [5:0]  mode;
    logic [11:0] flags;
    logic [12:0] mask, cfg;
    logic [31:0] rx;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;
    mdsfc_row_t  rows [7] = '{'{16'h3fff, 13'h0000}, '{16'hc0aa, 13'h0000},
        '{16'h4123, 13'h00aa}, '{16'h6000, 13'h00aa}, '{16'he0b8, 13'h0d98},
        '{16'h0000, 13'h00b8}, '{16'h2000, mdsfc_pkg::ID_PAYLOAD}};

    always #20 ref_clk = ~ref_clk;

    mdsfc_top #(.TURN_ON_CYC(TON)) dut_u (.ref_clk(ref_clk), .srst(srst), .clk_en(1'b1),
        .driver_enable_pin(en_pin), .disable_pin(dis_pin), .supply_ok(sup_ok),
        .supplies_ready(sup_rdy), .fault_in(flt), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .fault_status_n(fs_n), .bridge_hiz(hiz),
        .supplies_on(sup_on), .mode_state(mode), .status_flags(flags), .mask_reg(mask),
        .config_reg(cfg));
    mdsfc_host_model host_u (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe));

    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Bounded wait for a mode
    task automatic wait_mode(input logic [5:0] m, input int lim);
        int k;
        k = 0;
        while (mode !== m && k < lim)
        begin
            @(negedge ref_clk);
            k++;
        end
        `CHK("mode", m, mode);
    endtask

    // Hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        @(negedge ref_clk);
        `CHK("rst", {6'h01, 3'b110, 12'h0, 13'h06f1, 13'h0d98}, {mode, fs_n, hiz, sup_on, flags, mask, cfg});
        @(posedge ref_clk);
        en_pin <= 1'b1;
        wait_mode(mdsfc_pkg::ST_POWERUP, 8);
        `CHK("pulse", 1'b0, fs_n);
        wait_mode(mdsfc_pkg::ST_NORMAL, 200);
        // Rows: answer is the previously selected word
        foreach (rows[i])
        begin
            host_u.xfer(16, {16'h0, rows[i].tx}, rx);
            `CHK("rx", rows[i].exp, rx[12:0]);
        end
        `CHK("regs", {13'h00aa, 13'h00b8}, {mask, cfg});
        // Framing errors
        host_u.xfer(15, 32'h7fff, rx);
        `CHK("frm", 2'b11, {flags[11], cfg == 13'h00b8});
        host_u.xfer(16, 32'ha800, rx);
        `CHK("frm", 1'b0, flags[11]);
        host_u.xfer(0, 32'h0, rx);
        `CHK("frm", 1'b1, flags[11]);
        host_u.xfer(16, 32'ha800, rx);
        host_u.xfer(16, 32'h8000, rx);
        `CHK("frm", 1'b1, flags[11]);
        host_u.xfer(16, 32'ha800, rx);
        // Daisy chain
        host_u.xfer(32, 32'h9a5c_4000, rx);
        `CHK("chain", 16'h9a5c, rx[15:0]);
        host_u.xfer(16, 32'h2000, rx);
        `CHK("chain", 13'h00aa, rx[12:0]);
        // Fault latch and clears
        @(posedge ref_clk);
        flt <= 11'h002;
        repeat (10) @(negedge ref_clk);
        `CHK("flt", 3'b100, {flags[1], fs_n, hiz == 1'b0});
        `CHK("mode", mdsfc_pkg::ST_FAULT, mode);
        host_u.xfer(16, 32'ha002, rx);
        `CHK("flt", 1'b1, flags[1]);
        @(posedge ref_clk);
        flt <= 11'h000;
        repeat (10) @(negedge ref_clk);
        `CHK("flt", 1'b1, flags[1]);
        host_u.xfer(16, 32'ha002, rx);
        `CHK("flt", 1'b0, flags[1]);
        wait_mode(mdsfc_pkg::ST_NORMAL, 20);
        // Disable pulse clear
        @(posedge ref_clk);
        flt <= 11'h002;
        repeat (8) @(posedge ref_clk);
        flt <= 11'h000;
        dis_pin <= 1'b1;
        repeat (40) @(negedge ref_clk);
        `CHK("dis", 1'b0, fs_n);
        @(posedge ref_clk);
        dis_pin <= 1'b0;
        repeat (10) @(negedge ref_clk);
        `CHK("dis", 12'h000, flags);
        wait_mode(mdsfc_pkg::ST_NORMAL, 20);
        // Power-down, then wake
        host_u.xfer(16, 32'h4000, rx);
        @(posedge ref_clk);
        flt <= 11'h004;
        repeat (8) @(posedge ref_clk);
        flt <= 11'h000;
        en_pin <= 1'b0;
        repeat (6) @(negedge ref_clk);
        `CHK("pd", {mdsfc_pkg::ST_POWERDOWN, 2'b01}, {mode, fs_n, hiz});
        repeat (150) @(negedge ref_clk);
        `CHK("pd", mdsfc_pkg::ST_POWERDOWN, mode);
        wait_mode(mdsfc_pkg::ST_SLEEP, 100);
        `CHK("pd", 1'b1, fs_n);
        @(posedge ref_clk);
        en_pin <= 1'b1;
        wait_mode(mdsfc_pkg::ST_NORMAL, 200);
        `CHK("wake", 12'h000, flags);
        host_u.xfer(16, 32'h4000, rx);
        `CHK("wake", 12'h000, rx[11:0]);
        final_report();
    end
endmodule
`default_nettype wire
